/* File: rtl/aias_regs.svh */
`ifndef AIAS_REGS_SVH
`define AIAS_REGS_SVH
`define AIAS_STATUS_OFFSET 4'h9
`define AIAS_STATUS_RESET 16'h0000
`define AIAS_BIT_ADJ_MODE 15
`define AIAS_BIT_RANGE 12
`define AIAS_BIT_CHAN 13
`define AIAS_BIT_AVG 11
`define AIAS_MODE_NORMAL 8'h00
`define AIAS_MODE_ADJUST 8'h01
`define AIAS_AVG_MAX 16'h0006
`define AIAS_CHAN_MIN 8'h21
`define AIAS_CHAN_MAX 8'h28
`define AIAS_UNIT_MAX 7'd95
`define AIAS_ZERO_DATA 16'h0000
`define AIAS_MON_CYCLES 16'd2000
`endif

/* File: rtl/aias_pkg.sv */
package aias_pkg;
  typedef enum logic [1:0] {
    AIAS_RUN,
    AIAS_ADJUST,
    AIAS_HALT,
    AIAS_RESTART
  } aias_state_t;
  typedef struct packed {
    logic bus_error;
    logic cpu_watchdog;
    logic cpu_in_run;
  } aias_cpu_stat_t;
endpackage

/* File: rtl/aias_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for pin-level inputs.
module aias_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in, // System clock.
  input wire logic srst_in, // Synchronous reset.
  input wire logic [WIDTH-1:0] d_in, // Asynchronous level.
  output logic [WIDTH-1:0] q_out // Synchronised level.
);
  logic [WIDTH-1:0] meta;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

/* File: rtl/aias_alarm.sv */
`timescale 1ns/1ps
`include "aias_regs.svh"
module aias_alarm
  import aias_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter logic [15:0] MON_CYCLES = `AIAS_MON_CYCLES
) (
  input wire logic clk_in, // System clock.
  input wire logic srst_in, // Power-on reset.
  input wire logic mode_switch_in, // Front-panel adjust switch pin.
  input wire logic [6:0] unit_number_in, // Rotary unit number pin.
  input wire logic unit_dup_in, // Duplicate unit number from bus logic.
  input wire logic [15:0] restart_word_in, // Restart word holding this unit's bit.
  input wire logic [7:0] setting_mode_in, // Mode byte of setting memory.
  input wire logic setting_mode_sel_in, // High selects setting memory mode.
  input wire logic [15:0] avg_setting_in, // Averaging code.
  input wire logic [CHANNELS-1:0] chan_enable_in, // Channels set for use.
  input wire logic [7:0] adj_chan_in, // Channel chosen for adjustment.
  input wire logic adj_in_window_in, // Input lies inside adjust window.
  input wire logic adj_set_in, // Offset or gain update request.
  input wire logic [CHANNELS-1:0] wire_break_in, // Wire-break detection per channel.
  input wire logic [15:0] conv_data_in, // Live conversion value.
  input wire logic conv_valid_in, // Conversion cycle done pulse.
  input wire aias_cpu_stat_t cpu_stat_in, // CPU and bus condition.
  input wire logic refresh_in, // I/O refresh strobe.
  input wire logic [3:0] reg_addr_in, // Word offset read by refresh.
  output logic [15:0] reg_data_out, // Word returned to refresh.
  output logic [15:0] conv_data_out, // Conversion data to CPU.
  output logic [15:0] monitor_out, // Adjustment monitor word.
  output logic adj_update_out, // Offset or gain update accepted.
  output logic conv_enable_out, // Conversion may run.
  output logic unit_error_led_out, // Unit error indicator.
  output logic cpu_error_led_out, // CPU error indicator.
  output logic run_led_out, // Operating indicator.
  output logic adjust_mode_led_out // Adjustment indicator.
);
  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic sw_adj;
  logic [6:0] unit_num;
  // The switch and the unit number are pins, so they are retimed before use.
  // Both share one synchroniser, so they change on the same edge.
  aias_sync #(.WIDTH(8)) u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .d_in({mode_switch_in, unit_number_in}),
    .q_out({sw_adj, unit_num})
  );

  // ----------------------------------------
  // Restart detection
  // ----------------------------------------
  // Internal state shared by the processes below.
  logic rst_bit;
  logic rst_bit_d;
  logic restart_pulse;
  aias_state_t state;
  logic adj_mode;
  logic avg_alarm;
  logic unit_bad;
  logic [15:0] mon_cnt;
  logic mon_timeout;
  logic [15:0] status;
  logic range_alarm;
  logic chan_alarm;
  logic init_bad;
  logic halted;

  // Selects this unit's bit; unit n is bit n mod 16 of its word.
  assign rst_bit = restart_word_in[unit_num[3:0]];
  assign restart_pulse = rst_bit_d & ~rst_bit;

  // Delays the restart bit to find its falling edge.
  // Reset clears the delay, so no false falling edge follows reset.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rst_bit_d <= 1'b0;
    end else begin
      rst_bit_d <= rst_bit;
    end
  end

  // ----------------------------------------
  // Mode and setting checks
  // ----------------------------------------
  // Mode comes from the setting byte when selected, else the switch.
  // Any setting byte other than the adjust code means normal operation.
  // A bad averaging code blocks conversion until the next restart; a bad unit number blocks it only while it lasts.
  assign adj_mode = setting_mode_sel_in ? (setting_mode_in == `AIAS_MODE_ADJUST) : sw_adj;
  assign unit_bad = unit_dup_in | (unit_num > `AIAS_UNIT_MAX);
  assign init_bad = avg_alarm | unit_bad;
  assign halted = (state == AIAS_HALT);

  // Averaging alarm is caught at start-up and kept until restart.
  // A corrected code therefore shows no effect before the next restart.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      avg_alarm <= 1'b0;
    end else if (state == AIAS_RESTART) begin
      avg_alarm <= (avg_setting_in > `AIAS_AVG_MAX);
    end
  end

  // ----------------------------------------
  // Operating state
  // ----------------------------------------
  // Restart holds one cycle, then the unit runs or adjusts.
  // The unit also stays in restart while its restart bit is high.
  // A halt is left only through a restart or a reset.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= AIAS_RESTART;
    end else if (restart_pulse || rst_bit) begin
      state <= AIAS_RESTART;
    end else begin
      case (state)
        AIAS_RESTART: state <= adj_mode ? AIAS_ADJUST : AIAS_RUN;
        AIAS_RUN: state <= adj_mode ? AIAS_ADJUST : AIAS_RUN;
        AIAS_ADJUST: begin
          if (cpu_stat_in.cpu_in_run) begin
            state <= AIAS_HALT;
          end else if (!adj_mode) begin
            state <= AIAS_RUN;
          end
        end
        AIAS_HALT: state <= AIAS_HALT;
        default: state <= AIAS_RESTART;
      endcase
    end
  end

  // ----------------------------------------
  // CPU monitoring timer
  // ----------------------------------------
  // Counts cycles since the last refresh; expiry freezes the data.
  // The counter saturates, so a long silence cannot wrap round and thaw the data.
  always_ff @(posedge clk_in) begin
    if (srst_in || refresh_in || state == AIAS_RESTART) begin
      mon_cnt <= '0;
    end else if (mon_cnt != MON_CYCLES) begin
      mon_cnt <= mon_cnt + 16'd1;
    end
  end
  // Expiry stands until the next refresh or restart.
  assign mon_timeout = (mon_cnt == MON_CYCLES);

  // ----------------------------------------
  // Adjustment alarms
  // ----------------------------------------
  // Channel codes run upward from the first code, one per channel.
  logic chan_ok;
  logic [7:0] chan_idx;
  assign chan_idx = adj_chan_in - `AIAS_CHAN_MIN;
  assign chan_ok = (adj_chan_in >= `AIAS_CHAN_MIN) && (adj_chan_in <= `AIAS_CHAN_MAX)
                   && (chan_idx < 8'(CHANNELS)) && chan_enable_in[chan_idx[2:0]];

  // Adjust alarms follow their cause while adjusting.
  // A bad channel masks the range check, as there is no input to judge.
  // Both flags drop as soon as adjustment mode ends.
  always_ff @(posedge clk_in) begin
    if (srst_in || state != AIAS_ADJUST) begin
      range_alarm <= 1'b0;
      chan_alarm <= 1'b0;
    end else begin
      chan_alarm <= ~chan_ok;
      range_alarm <= chan_ok & ~adj_in_window_in;
    end
  end

  // Update passes only with a good channel and an input in window.
  // A refused update leaves the stored offset and gain as they were.
  assign adj_update_out = (state == AIAS_ADJUST) & adj_set_in & chan_ok & adj_in_window_in;

  // ----------------------------------------
  // Alarm status word
  // ----------------------------------------
  // Rebuilt every conversion cycle; held on timeout, forced on halt.
  // A halt forces the word so that only the adjustment bit reads set.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      status <= `AIAS_STATUS_RESET;
    end else if (halted) begin
      status <= 16'h0000;
      status[`AIAS_BIT_ADJ_MODE] <= 1'b1;
    end else if ((conv_valid_in || state == AIAS_RESTART) && !mon_timeout) begin
      status <= 16'h0000;
      status[`AIAS_BIT_ADJ_MODE] <= (state == AIAS_ADJUST);
      status[`AIAS_BIT_CHAN] <= chan_alarm;
      status[`AIAS_BIT_RANGE] <= range_alarm;
      status[`AIAS_BIT_AVG] <= avg_alarm;
      status[CHANNELS-1:0] <= wire_break_in & chan_enable_in;
    end
  end

  // Refresh reads the status word; other words read zero.
  // The word stands until the next refresh, so the controller may read it late.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_data_out <= 16'h0000;
    end else if (refresh_in) begin
      reg_data_out <= (reg_addr_in == `AIAS_STATUS_OFFSET) ? status : 16'h0000;
    end
  end

  // ----------------------------------------
  // Conversion data path
  // ----------------------------------------
  // Conversion runs only in run or adjust mode with a sound setup.
  assign conv_enable_out = (state == AIAS_RUN || state == AIAS_ADJUST) && !init_bad;

  // Zero or hold data according to the error in force.
  // Restart, bus error and bad setup zero the data ahead of any hold.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      conv_data_out <= `AIAS_ZERO_DATA;
    end else if (state == AIAS_RESTART) begin
      conv_data_out <= `AIAS_ZERO_DATA;
    end else if (cpu_stat_in.bus_error) begin
      conv_data_out <= `AIAS_ZERO_DATA;
    end else if (init_bad) begin
      conv_data_out <= `AIAS_ZERO_DATA;
    end else if (halted || mon_timeout) begin
      conv_data_out <= conv_data_out;
    end else if (conv_valid_in) begin
      // Watchdog leaves data free running, which is allowed to be undefined.
      conv_data_out <= (|(wire_break_in & chan_enable_in)) ? `AIAS_ZERO_DATA : conv_data_in;
    end
  end

  // Monitor word is live while adjusting, held otherwise.
  // A bad channel freezes it, while a range alarm keeps it live.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      monitor_out <= `AIAS_ZERO_DATA;
    end else if (state == AIAS_ADJUST && conv_valid_in && !chan_alarm) begin
      monitor_out <= conv_data_in;
    end
  end

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  // The unit-error indicator lights for the averaging, channel, range and wire-break alarms and for a halt.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      unit_error_led_out <= 1'b0;
    end else begin
      unit_error_led_out <= avg_alarm | chan_alarm | range_alarm | halted
                            | (|(wire_break_in & chan_enable_in));
    end
  end

  // The CPU-error indicator lights for link faults and a bad unit number.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cpu_error_led_out <= 1'b0;
    end else begin
      cpu_error_led_out <= cpu_stat_in.bus_error | cpu_stat_in.cpu_watchdog
                           | mon_timeout | unit_bad;
    end
  end

  // The operating indicator goes dark while setup is wrong or a restart runs.
  // A watchdog error leaves it lit, so the two faults can be told apart.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      run_led_out <= 1'b0;
    end else begin
      run_led_out <= !init_bad && state != AIAS_RESTART;
    end
  end

  // The adjust indicator stays lit through a halt so the cause stays visible.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      adjust_mode_led_out <= 1'b0;
    end else begin
      adjust_mode_led_out <= (state == AIAS_ADJUST) | halted;
    end
  end
endmodule

/* File: tb/aias_alarm_sva.sv */
`timescale 1ns/1ps
// Checks error handling and refresh behaviour at the alarm block's ports.
module aias_alarm_sva
  import aias_pkg::*;
(
  input wire logic clk_in, // Clock.
  input wire logic srst_in, // Reset.
  input wire logic unit_dup_in, // Duplicate unit.
  input wire aias_cpu_stat_t cpu_stat_in, // CPU state.
  input wire logic [7:0] adj_chan_in, // Adjust channel.
  input wire logic adj_in_window_in, // Inside window.
  input wire logic adj_set_in, // Update request.
  input wire logic refresh_in, // Refresh strobe.
  input wire logic [3:0] reg_addr_in, // Word offset.
  input wire logic [15:0] reg_data_out, // Read word.
  input wire logic [15:0] conv_data_out, // Conversion data.
  input wire logic adj_update_out, // Update accepted.
  input wire logic conv_enable_out, // Conversion permit.
  input wire logic cpu_error_led_out, // CPU error.
  input wire logic run_led_out // Operating.
);
  // All checks share the one clock and its synchronous reset.
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_unmapped_reads_zero: assert property (refresh_in && reg_addr_in != 4'h9 |=> reg_data_out == 16'h0000)
    else $error("unmapped offset returned data");
  a_word_stands: assert property (!refresh_in |=> $stable(reg_data_out))
    else $error("read word changed without refresh");
  a_bus_err_zero: assert property (cpu_stat_in.bus_error [*3] |-> conv_data_out == 16'h0000)
    else $error("bus error left data nonzero");
  a_bus_err_led: assert property (cpu_stat_in.bus_error [*3] |-> cpu_error_led_out)
    else $error("bus error left CPU indicator dark");
  a_dup_stops_conv: assert property (unit_dup_in [*8] |-> !conv_enable_out && !run_led_out)
    else $error("duplicate unit still converting");
  a_dup_zero_data: assert property (unit_dup_in [*8] |-> conv_data_out == 16'h0000 && cpu_error_led_out)
    else $error("duplicate unit data or indicator wrong");
  a_restart_zero: assert property ($fell(srst_in) |-> (conv_data_out == 16'h0000) [*2])
    else $error("data nonzero during restart");
  a_update_window: assert property (adj_update_out |-> adj_in_window_in && adj_set_in)
    else $error("update accepted outside window");
  a_update_channel: assert property (adj_update_out |-> adj_chan_in >= 8'h21 && adj_chan_in <= 8'h28)
    else $error("update accepted on bad channel");
  cover property (refresh_in && reg_addr_in == 4'h9);
  cover property (adj_update_out);
  cover property (unit_dup_in [*8]);
endmodule
bind aias_alarm aias_alarm_sva u_sva (.clk_in(clk_in), .srst_in(srst_in), .unit_dup_in(unit_dup_in),
  .cpu_stat_in(cpu_stat_in), .adj_chan_in(adj_chan_in), .adj_in_window_in(adj_in_window_in),
  .adj_set_in(adj_set_in), .refresh_in(refresh_in), .reg_addr_in(reg_addr_in), .reg_data_out(reg_data_out),
  .conv_data_out(conv_data_out), .adj_update_out(adj_update_out), .conv_enable_out(conv_enable_out),
  .cpu_error_led_out(cpu_error_led_out), .run_led_out(run_led_out));

/* File: tb/aias_cpu_model.sv */
`timescale 1ns/1ps
// Controller side: refresh strobes and restart bits. One unit is mounted and the
// table always matches it, so no configuration error is raised.
module aias_cpu_model (
  input wire logic clk_in, // System clock.
  output logic refresh_out, // Refresh strobe.
  output logic [3:0] addr_out, // Word offset.
  output logic [15:0] restart_word_out // Restart word.
);
  // Idle bus at time zero.
  initial begin
    refresh_out = 1'b0;
    addr_out = 4'h0;
    restart_word_out = 16'h0000;
  end
  // One refresh; the released offset is inverted so stale values never pass.
  task automatic refresh(input logic [3:0] addr);
    @(negedge clk_in);
    refresh_out = 1'b1;
    addr_out = addr;
    @(negedge clk_in);
    refresh_out = 1'b0;
    addr_out = ~addr;
  endtask
  // Restart bit of a unit pulsed on then off, then time for the restart.
  task automatic restart(input int unsigned unit);
    @(negedge clk_in);
    restart_word_out[unit % 16] = 1'b1;
    repeat (2) @(negedge clk_in);
    restart_word_out[unit % 16] = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import aias_pkg::*;
  logic clk_in, srst_in, mode_switch_in, unit_dup_in, setting_mode_sel_in, adj_in_window_in, adj_set_in;
  logic conv_valid_in, refresh_in, adj_update_out, conv_enable_out, unit_error_led_out, cpu_error_led_out;
  logic run_led_out, adjust_mode_led_out, ref_d;
  logic [6:0] unit_number_in;
  logic [3:0] reg_addr_in;
  logic [7:0] setting_mode_in, chan_enable_in, adj_chan_in, wire_break_in;
  logic [15:0] restart_word_in, avg_setting_in, conv_data_in, reg_data_out, conv_data_out, monitor_out, hold;
  aias_cpu_stat_t cpu_stat_in;
  logic [15:0] exp_q[$];
  logic [7:0] chans [4] = '{8'h21, 8'h28, 8'h29, 8'h23};
  logic [15:0] stat [4] = '{16'h8000, 16'h9000, 16'ha000, 16'ha000};
  int mismatches, total_checks;
  aias_alarm #(.CHANNELS(8), .MON_CYCLES(16'h0008)) uut (.*);
  aias_cpu_model cpu (.clk_in(clk_in), .refresh_out(refresh_in), .addr_out(reg_addr_in),
    .restart_word_out(restart_word_in));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Notes the expected word, then asks the controller model for it.
  task automatic rd(input logic [3:0] addr, input logic [15:0] exp);
    exp_q.push_back(exp);
    cpu.refresh(addr);
  endtask
  // One conversion-done pulse with a random live value.
  task automatic conv();
    @(negedge clk_in);
    conv_valid_in = 1'b1;
    conv_data_in = 16'($urandom);
    @(negedge clk_in);
    conv_valid_in = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // The word read at a refresh is compared one cycle later with the oldest note.
  always @(posedge clk_in) ref_d <= refresh_in;
  always @(negedge clk_in) if (ref_d) chk("status", exp_q.pop_front(), reg_data_out);
  initial begin
    #300000;
    mismatches++;
    print_verdict();
  end
  initial begin
    {mode_switch_in, unit_dup_in, setting_mode_sel_in, adj_in_window_in, adj_set_in, conv_valid_in} = '0;
    {setting_mode_in, adj_chan_in, wire_break_in, avg_setting_in, conv_data_in, cpu_stat_in} = '0;
    unit_number_in = 7'd5;
    chan_enable_in = 8'hff;
    srst_in = 1'b1;
    void'($urandom(59331));
    repeat (10) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    repeat (4) begin
      wire_break_in = 8'($urandom);
      setting_mode_in = 8'($urandom); // Ignored while the switch selects the mode.
      conv();
      rd(4'h9, {8'h00, wire_break_in});
      chk("unit_error", 16'(wire_break_in != 8'h00), 16'(unit_error_led_out));
      chk("adj_led", 16'h0000, 16'(adjust_mode_led_out));
      rd(4'($urandom_range(8, 0)), 16'h0000);
    end
    wire_break_in = 8'h00;
    chan_enable_in = 8'hfb;
    mode_switch_in = 1'b1;
    adj_set_in = 1'b1;
    repeat (4) @(negedge clk_in);
    for (int i = 0; i < 4; i++) begin
      adj_chan_in = chans[i];
      adj_in_window_in = (i != 1);
      #1 chk("update", 16'(i == 0), 16'(adj_update_out));
      conv();
      if (i < 2) begin
        hold = conv_data_in;
      end
      chk("monitor", hold, monitor_out);
      chk("adj_led", 16'h0001, 16'(adjust_mode_led_out));
      rd(4'h9, stat[i]);
    end
    adj_chan_in = 8'h21;
    adj_in_window_in = 1'b0;
    cpu_stat_in.cpu_in_run = 1'b1;
    conv();
    rd(4'h9, 16'h8000);
    hold = conv_data_out;
    conv();
    chk("held_data", hold, conv_data_out);
    {mode_switch_in, adj_set_in, cpu_stat_in.cpu_in_run} = '0;
    chan_enable_in = 8'hff;
    avg_setting_in = 16'($urandom_range(16'hffff, 16'h0007));
    cpu.restart(5);
    conv();
    rd(4'h9, 16'h0800);
    chk("conv_data", 16'h0000, conv_data_out);
    chk("leds", 16'h0004, {13'h0, unit_error_led_out, run_led_out, conv_enable_out});
    avg_setting_in = 16'($urandom_range(16'h0006, 16'h0000));
    conv();
    rd(4'h9, 16'h0800);
    cpu.restart(5);
    conv();
    rd(4'h9, 16'h0000);
    cpu_stat_in.bus_error = 1'b1;
    conv();
    chk("bus_data", 16'h0000, conv_data_out);
    chk("bus_led", 16'h0001, 16'(cpu_error_led_out));
    cpu_stat_in.bus_error = 1'b0;
    // No refresh for longer than the monitoring period: data freezes, CPU error lights.
    conv();
    repeat (10) @(negedge clk_in);
    hold = conv_data_out;
    conv();
    chk("timeout_data", hold, conv_data_out);
    chk("timeout_led", 16'h0001, 16'(cpu_error_led_out));
    for (int i = 0; i < 2; i++) begin
      unit_number_in = (i == 1) ? 7'd5 : 7'd96;
      unit_dup_in = (i == 1);
      cpu.restart(int'(unit_number_in));
      conv();
      chk("unit_fault", 16'h0004, {13'h0, cpu_error_led_out, run_led_out, conv_enable_out});
      chk("unit_data", 16'h0000, conv_data_out);
    end
    unit_dup_in = 1'b0;
    adj_in_window_in = 1'b1;
    cpu.restart(5);
    setting_mode_sel_in = 1'b1;
    setting_mode_in = 8'h01;
    repeat (4) @(negedge clk_in);
    conv();
    rd(4'h9, 16'h8000);
    {setting_mode_sel_in, setting_mode_in} = '0;
    cpu.restart(5);
    cpu_stat_in.cpu_watchdog = 1'b1;
    conv();
    chk("wdt_leds", 16'h0003, {14'h0, cpu_error_led_out, run_led_out});
    repeat (2) @(negedge clk_in);
    print_verdict();
  end
endmodule
